// File: lp_loop_ctrl.sv
/*
 * loop controller: apb registers, loop tables, port loop paths.
 * assumes apb on pclk; facility pins, far requests asynchronous.
 */
// Local design decisions: the APB slave port and the placing of the registers.
//
// Behaviour
// R1: each vt1.5 loops alone to its own sts-1
// R2: sts-1 line loop keeps violations and timing
// R3: vt and sts-1 line loops alter no bit
// R4: ds1 loop: one port or a port range
// R5: ds1 line loop returns input to facility
// R6: terminal loop via switch; ds1 on listed cards only
// R7: internal loop returns output to switch
// R8: tributary loop on ds3 card, near or far end
// R9: ds3 line loop in card, keeps overhead, violations
// R10: ds3 line loop keeps timing
// R11: ds3 line loop by command or far-end request
// R12: sts-1 loop: port or range, line or terminal
// R13: sts-1 terminal loop only at the near end
// R14: vt1.5 loop: terminal only, one tributary
// R15: one loop per port; bad loop/card pairs rejected
module lp_loop_ctrl
    import lp_pkg::*;
(
    // apb
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [LP_AW-1:0]       paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // ds1 ports
    input  wire lp_sym_s                ds1_fac_rx [LP_NUM_DS1],
    output lp_sym_s                     ds1_fac_tx [LP_NUM_DS1],
    input  wire lp_sym_s                ds1_sw_rx  [LP_NUM_DS1],
    output lp_sym_s                     ds1_sw_tx  [LP_NUM_DS1],
    // sts-1 ports
    input  wire lp_sym_s                sts1_fac_rx [LP_NUM_STS1],
    output lp_sym_s                     sts1_fac_tx [LP_NUM_STS1],
    input  wire lp_sym_s                sts1_sw_rx  [LP_NUM_STS1],
    output lp_sym_s                     sts1_sw_tx  [LP_NUM_STS1],
    // ds3 ports
    input  wire lp_sym_s                ds3_fac_rx [LP_NUM_DS3],
    output lp_sym_s                     ds3_fac_tx [LP_NUM_DS3],
    input  wire lp_sym_s                ds3_sw_rx  [LP_NUM_DS3],
    output lp_sym_s                     ds3_sw_tx  [LP_NUM_DS3],
    input  wire logic [LP_NUM_DS3-1:0]  ds3_far_loop_req,
    // to switch matrix and ds3 demux
    output logic [LP_NUM_TRIB-1:0]      vt_loop_mask [LP_NUM_STS1],
    output logic [LP_NUM_DS3-1:0]       tributary_loop_en,
    output logic [LP_NUM_DS3-1:0]       tributary_loop_far,
    output logic [4:0]                  tributary_loop_sel [LP_NUM_DS3]
);

    typedef enum logic {ST_IDLE, ST_APPLY} lp_state_e;

    lp_state_e              state_r;
    logic [31:0]            cmd_r;
    logic [3:0]             stat_r;
    logic [3:0]             idx_r;
    lp_loop_e               ds1_mode_r  [LP_NUM_DS1];
    lp_loop_e               sts1_mode_r [LP_NUM_STS1];
    lp_loop_e               ds3_mode_r  [LP_NUM_DS3];
    lp_loop_e               ds3_eff     [LP_NUM_DS3];
    logic [4:0]             ds3_trib_r  [LP_NUM_DS3];
    logic [LP_NUM_DS3-1:0]  ds3_far_r;
    logic [LP_NUM_DS3-1:0]  feac_m_r;
    logic [LP_NUM_DS3-1:0]  feac_s_r;
    logic [LP_NUM_TRIB-1:0] vt_mask_r [LP_NUM_STS1];

    logic                   wr_acc;
    logic                   go_req;
    logic                   cmd_ok;
    logic                   conflict;
    logic                   step;
    logic [31:0]            rd_nxt;
    logic                   err_nxt;
    lp_class_e              c_cls;
    lp_loop_e               c_loop;
    lp_card_e               c_card;
    logic                   c_far;
    logic [4:0]             c_trib;
    logic [3:0]             c_first;
    logic [3:0]             c_last;
    logic [4:0]             trib_idx;

    // ------------------------------------------------------------
    // decode: new word at go, else the held one
    // ------------------------------------------------------------
    logic [31:0] cw;
    assign cw       = (state_r == ST_IDLE) ? pwdata : cmd_r;
    assign c_cls    = lp_class_e'(cw[LP_CMD_CLASS_LSB +: 2]);
    assign c_loop   = lp_loop_e'(cw[LP_CMD_LOOP_LSB +: 3]);
    assign c_card   = lp_card_e'(cw[LP_CMD_CARD_LSB +: 3]);
    assign c_far    = cw[LP_CMD_FAR_BIT];
    assign c_trib   = cw[LP_CMD_TRIB_LSB +: 5];
    assign c_first  = cw[LP_CMD_FIRST_LSB +: 4];
    assign c_last   = cw[LP_CMD_LAST_LSB +: 4];
    assign trib_idx = c_trib - 5'h01;

    assign wr_acc = psel && penable && pwrite;
    assign go_req = wr_acc && (paddr == LP_CMD_OFS) &&
                    pwdata[LP_CMD_GO_BIT] && (state_r == ST_IDLE);

    // ------------------------------------------------------------
    // legality of loop type against class and card
    // ------------------------------------------------------------
    always_comb
    begin
        logic range_ok;
        logic one_port;
        logic trib_ok;
        range_ok = 1'b0;
        one_port = (c_first == c_last);
        trib_ok  = (c_trib != 5'h00) && (c_trib <= 5'(LP_NUM_TRIB));
        cmd_ok   = 1'b0;
        unique case (c_cls)
            CLS_DS1:  range_ok = (c_first <= c_last) &&
                                 (c_last < 4'(LP_NUM_DS1));   // see R4
            CLS_STS1: range_ok = (c_first <= c_last) &&
                                 (c_last < 4'(LP_NUM_STS1));  // see R12
            default:  range_ok = one_port &&
                                 (c_last < 4'(LP_NUM_DS3));
        endcase
        unique case (c_cls)
            CLS_DS1:
                case (c_loop)
                    LOOP_NONE, LOOP_FACILITY_LINE,
                    LOOP_INTERNAL_SWITCHWARD: cmd_ok = 1'b1;
                    LOOP_SWITCH_TERMINAL:                     // see R6
                        cmd_ok = c_card inside {CARD_DS1_INTERFACE,
                                 CARD_MUX_ONE, CARD_DS3_INTERFACE,
                                 CARD_SONET_ONE};
                    default: cmd_ok = 1'b0;                   // see R15
                endcase
            CLS_DS3:
                case (c_loop)
                    LOOP_NONE:          cmd_ok = 1'b1;
                    LOOP_FACILITY_LINE:                       // see R9
                        cmd_ok = (c_card == CARD_DS3_INTERFACE);
                    LOOP_TRIBUTARY:                           // see R8
                        cmd_ok = (c_card == CARD_DS3_INTERFACE) &&
                                 trib_ok;
                    default:            cmd_ok = 1'b0;
                endcase
            CLS_STS1:
                case (c_loop)
                    LOOP_NONE, LOOP_FACILITY_LINE: cmd_ok = 1'b1;
                    LOOP_SWITCH_TERMINAL:                     // see R13
                        cmd_ok = (c_card == CARD_STS1_INTERFACE) &&
                                 !c_far;
                    default: cmd_ok = 1'b0;
                endcase
            CLS_VT:                                           // see R14
                cmd_ok = ((c_loop == LOOP_NONE) ||
                          (c_loop == LOOP_SWITCH_TERMINAL)) &&
                         (c_card == CARD_STS1_INTERFACE) && trib_ok &&
                         (c_last < 4'(LP_NUM_STS1));
        endcase
        cmd_ok = cmd_ok && range_ok;
    end

    // ------------------------------------------------------------
    // one loop per entry
    // ------------------------------------------------------------
    always_comb
    begin
        lp_loop_e cur;
        cur = LOOP_NONE;
        unique case (c_cls)
            CLS_DS1:  cur = ds1_mode_r[idx_r[2:0]];
            CLS_STS1: cur = sts1_mode_r[idx_r[0]];
            CLS_DS3:  cur = ds3_mode_r[idx_r[0]];
            CLS_VT:   cur = vt_mask_r[idx_r[0]][trib_idx] ?
                            LOOP_SWITCH_TERMINAL : LOOP_NONE;
        endcase
        conflict = (c_loop != LOOP_NONE) && (cur != LOOP_NONE) &&
                   (cur != c_loop);                           // see R15
        if (c_cls == CLS_DS3 && cur == LOOP_TRIBUTARY &&
            c_loop == LOOP_TRIBUTARY &&
            ds3_trib_r[idx_r[0]] != c_trib)
            conflict = 1'b1;
    end

    assign step = (state_r == ST_APPLY) && !conflict;

    // ------------------------------------------------------------
    // sequencer, one port per cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_IDLE;
            cmd_r   <= LP_CMD_RST;
            idx_r   <= 4'h0;
            stat_r  <= LP_STAT_RST;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (go_req)
                    begin
                        cmd_r <= pwdata;
                        idx_r <= c_first;
                        stat_r <= cmd_ok ? 4'h1 : 4'h4;
                        if (cmd_ok)
                            state_r <= ST_APPLY;
                    end
                ST_APPLY:
                begin
                    if (conflict)
                        stat_r[LP_ST_CONF_BIT] <= 1'b1;
                    if (idx_r == c_last)
                    begin
                        state_r <= ST_IDLE;
                        stat_r[LP_ST_BUSY_BIT] <= 1'b0;
                        stat_r[LP_ST_DONE_BIT] <= 1'b1;
                    end
                    else
                        idx_r <= idx_r + 4'h1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // loop tables, one per port family
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ds1_mode_r <= '{default: LOOP_NONE};
        else if (step && c_cls == CLS_DS1)
            ds1_mode_r[idx_r[2:0]] <= c_loop;                 // see R4
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sts1_mode_r <= '{default: LOOP_NONE};
        else if (step && c_cls == CLS_STS1)
            sts1_mode_r[idx_r[0]] <= c_loop;                  // see R12
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ds3_mode_r <= '{default: LOOP_NONE};
            ds3_trib_r <= '{default: 5'h00};
            ds3_far_r  <= '0;
        end
        else if (step && c_cls == CLS_DS3)
        begin
            ds3_mode_r[idx_r[0]] <= c_loop;                   // see R11
            ds3_trib_r[idx_r[0]] <= c_trib;
            ds3_far_r[idx_r[0]]  <= c_far;                    // see R8
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vt_mask_r <= '{default: '0};
        else if (step && c_cls == CLS_VT)
            vt_mask_r[idx_r[0]][trib_idx] <=
                (c_loop == LOOP_SWITCH_TERMINAL);             // see R1 see R14
    end

    // far-end embedded loop request, synchronised
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            feac_m_r <= '0;
            feac_s_r <= '0;
        end
        else
        begin
            feac_m_r <= ds3_far_loop_req;
            feac_s_r <= feac_m_r;
        end
    end

    // ------------------------------------------------------------
    // port paths; ds3 line loop never enters the switch
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < LP_NUM_DS1; g++)
        begin : g_ds1
            lp_port_loop u_port (
                .pclk    (pclk),
                .presetn (presetn),
                .mode    (ds1_mode_r[g]),
                .fac_rx  (ds1_fac_rx[g]),
                .fac_tx  (ds1_fac_tx[g]),
                .sw_rx   (ds1_sw_rx[g]),
                .sw_tx   (ds1_sw_tx[g])
            );
        end
        for (g = 0; g < LP_NUM_STS1; g++)
        begin : g_sts1
            lp_port_loop u_port (
                .pclk    (pclk),
                .presetn (presetn),
                .mode    (sts1_mode_r[g]),
                .fac_rx  (sts1_fac_rx[g]),
                .fac_tx  (sts1_fac_tx[g]),
                .sw_rx   (sts1_sw_rx[g]),
                .sw_tx   (sts1_sw_tx[g])
            );
        end
        for (g = 0; g < LP_NUM_DS3; g++)
        begin : g_ds3
            // command or far-end request; a held tributary loop wins
            assign ds3_eff[g] = ((ds3_mode_r[g] == LOOP_FACILITY_LINE) ||
                                 (feac_s_r[g] &&
                                  ds3_mode_r[g] == LOOP_NONE)) ?
                                LOOP_FACILITY_LINE : LOOP_NONE; // see R11
            lp_port_loop u_port (
                .pclk    (pclk),
                .presetn (presetn),
                .mode    (ds3_eff[g]),                        // see R10
                .fac_rx  (ds3_fac_rx[g]),
                .fac_tx  (ds3_fac_tx[g]),
                .sw_rx   (ds3_sw_rx[g]),
                .sw_tx   (ds3_sw_tx[g])
            );
            assign tributary_loop_en[g]  = ds3_mode_r[g] == LOOP_TRIBUTARY;
            assign tributary_loop_far[g] = ds3_far_r[g];
            assign tributary_loop_sel[g] = ds3_trib_r[g];
        end
        for (g = 0; g < LP_NUM_STS1; g++)
        begin : g_vt
            assign vt_loop_mask[g] = vt_mask_r[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // apb read mux, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb
    begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            LP_CMD_OFS:
            begin
                rd_nxt  = cmd_r;
                err_nxt = pwrite && (state_r != ST_IDLE);
            end
            LP_STATUS_OFS: rd_nxt = {28'h000_0000, stat_r};
            LP_DS1_OFS:
                for (int i = 0; i < LP_NUM_DS1; i++)
                    rd_nxt[3*i +: 3] = ds1_mode_r[i];
            LP_SONET_OFS:
            begin
                for (int i = 0; i < LP_NUM_STS1; i++)
                    rd_nxt[3*i +: 3] = sts1_mode_r[i];
                for (int i = 0; i < LP_NUM_DS3; i++)
                begin
                    rd_nxt[LP_SN_DS3_LSB + 3*i +: 3] = ds3_mode_r[i];
                    rd_nxt[LP_SN_EFF_LSB + i] =
                        ds3_eff[i] == LOOP_FACILITY_LINE;
                    rd_nxt[LP_SN_FEAC_LSB + i] = feac_s_r[i];
                    rd_nxt[LP_SN_TRIB_LSB + 5*i +: 5] = ds3_trib_r[i];
                    rd_nxt[LP_SN_FAR_LSB + i] = ds3_far_r[i];
                end
            end
            LP_VT0_OFS: rd_nxt = {4'h0, vt_mask_r[0]};
            LP_VT1_OFS: rd_nxt = {4'h0, vt_mask_r[1]};
            default:    err_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= err_nxt;
        end
    end

    // no wait states
    assign pready = 1'b1;

endmodule // lp_loop_ctrl

// File: lp_pkg.sv
/*
 * loop controller package: register map, fields, resets, enums.
 * assumes a 32-bit apb master and one clock for all logic.
 */
package lp_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int LP_NUM_DS1   = 8;
    localparam int LP_NUM_STS1  = 2;
    localparam int LP_NUM_DS3   = 2;
    localparam int LP_NUM_TRIB  = 28;
    localparam int LP_AW        = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [LP_AW-1:0] LP_CMD_OFS     = 8'h00;
    localparam logic [LP_AW-1:0] LP_STATUS_OFS  = 8'h04;
    localparam logic [LP_AW-1:0] LP_DS1_OFS     = 8'h08;
    localparam logic [LP_AW-1:0] LP_SONET_OFS   = 8'h0C;
    localparam logic [LP_AW-1:0] LP_VT0_OFS     = 8'h10;
    localparam logic [LP_AW-1:0] LP_VT1_OFS     = 8'h14;

    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int LP_CMD_CLASS_LSB = 0;
    localparam int LP_CMD_LOOP_LSB  = 2;
    localparam int LP_CMD_FAR_BIT   = 5;
    localparam int LP_CMD_CARD_LSB  = 6;
    localparam int LP_CMD_TRIB_LSB  = 9;
    localparam int LP_CMD_FIRST_LSB = 16;
    localparam int LP_CMD_LAST_LSB  = 20;
    localparam int LP_CMD_GO_BIT    = 31;

    // status bits
    localparam int LP_ST_BUSY_BIT   = 0;
    localparam int LP_ST_DONE_BIT   = 1;
    localparam int LP_ST_REJ_BIT    = 2;
    localparam int LP_ST_CONF_BIT   = 3;

    // sonet / ds3 readback fields
    localparam int LP_SN_DS3_LSB    = 6;
    localparam int LP_SN_EFF_LSB    = 12;
    localparam int LP_SN_FEAC_LSB   = 14;
    localparam int LP_SN_TRIB_LSB   = 16;
    localparam int LP_SN_FAR_LSB    = 26;

    localparam logic [31:0] LP_CMD_RST  = 32'h0000_0000;
    localparam logic [3:0]  LP_STAT_RST = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CLS_DS1, CLS_DS3, CLS_STS1, CLS_VT
    } lp_class_e;

    typedef enum logic [2:0] {
        LOOP_NONE,
        LOOP_FACILITY_LINE,
        LOOP_SWITCH_TERMINAL,
        LOOP_INTERNAL_SWITCHWARD,
        LOOP_TRIBUTARY
    } lp_loop_e;

    typedef enum logic [2:0] {
        CARD_DS1_INTERFACE,
        CARD_MUX_ONE,
        CARD_DS3_INTERFACE,
        CARD_SONET_ONE,
        CARD_STS1_INTERFACE
    } lp_card_e;

    // line symbol plus violation mark
    typedef struct packed {
        logic data;
        logic viol;
    } lp_sym_s;

endpackage

// File: lp_port_loop.sv
/*
 * loop switch of one port between facility and switch sides.
 * assumes facility input asynchronous, switch input on pclk.
 */
module lp_port_loop
    import lp_pkg::*;
(
    // clock and reset
    input  wire logic     pclk,
    input  wire logic     presetn,
    // selection
    input  wire lp_loop_e mode,
    // facility side
    input  wire lp_sym_s  fac_rx,
    output lp_sym_s       fac_tx,
    // switch side
    input  wire lp_sym_s  sw_rx,
    output lp_sym_s       sw_tx
);

    lp_sym_s fac_m_r;
    lp_sym_s fac_s_r;
    lp_sym_s turn_r;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fac_m_r <= '0;
            fac_s_r <= '0;
        end
        else
        begin
            fac_m_r <= fac_rx;
            fac_s_r <= fac_m_r;
        end
    end

    // one stage stands for the matrix pass
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            turn_r <= '0;
        else
            turn_r <= fac_s_r;
    end

    // ------------------------------------------------------------
    // path select; whole symbol moves so violations survive
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fac_tx <= '0;
            sw_tx  <= '0;
        end
        else
        begin
            unique case (mode)
                LOOP_FACILITY_LINE:
                begin
                    fac_tx <= fac_s_r;   // see R2 see R5 see R9 see R3
                    sw_tx  <= fac_s_r;
                end
                LOOP_SWITCH_TERMINAL:
                begin
                    fac_tx <= turn_r;    // see R6 see R12
                    sw_tx  <= fac_s_r;
                end
                LOOP_INTERNAL_SWITCHWARD:
                begin
                    fac_tx <= sw_rx;
                    sw_tx  <= sw_rx;     // see R7
                end
                default:
                begin
                    fac_tx <= sw_rx;
                    sw_tx  <= fac_s_r;
                end
            endcase
        end
    end

endmodule // lp_port_loop

// File: lp_loop_ctrl_checker.sv
/* port assertions for the loop controller.
   assumes bind onto lp_loop_ctrl, one pclk domain. */
module lp_chk
    import lp_pkg::*;
(
    // apb
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [LP_AW-1:0] paddr,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // ports
    input wire lp_sym_s          ds1_fac_rx [LP_NUM_DS1],
    input wire lp_sym_s          ds1_fac_tx [LP_NUM_DS1],
    input wire lp_sym_s          ds1_sw_rx  [LP_NUM_DS1],
    input wire lp_sym_s          sts1_fac_rx [LP_NUM_STS1],
    input wire lp_sym_s          sts1_fac_tx [LP_NUM_STS1],
    input wire lp_sym_s          sts1_sw_rx  [LP_NUM_STS1],
    input wire logic [1:0]       tributary_loop_en,
    input wire logic [4:0]       tributary_loop_sel [LP_NUM_DS3]
);
    // ----
    // checks
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_high_a: assert property (pready) else $error("pready low");
    unmapped_err_a: assert property (psel && penable && paddr > 8'h14
        |-> pslverr && prdata == 32'h0) else $error("unmapped");
    status_ok_a: assert property (psel && penable && paddr == LP_STATUS_OFS
        |-> !pslverr) else $error("status err");
    rdata_hold_a: assert property (psel && penable && !pwrite ##1 !psel
        |-> $stable(prdata)) else $error("prdata moved");
    err_hold_a: assert property (psel && penable ##1 !psel
        |-> $stable(pslverr)) else $error("pslverr moved");
    trib_sel_a: assert property (tributary_loop_en[0]
        |-> tributary_loop_sel[0] inside {[5'd1:5'd28]}) else $error("trib");
    ds1_path_a: assert property (ds1_fac_tx[2] == $past(ds1_sw_rx[2])
        || ds1_fac_tx[2] == $past(ds1_fac_rx[2], 3)) else $error("ds1 path");
    sts1_path_a: assert property (sts1_fac_tx[0] == $past(sts1_sw_rx[0])
        || sts1_fac_tx[0] == $past(sts1_fac_rx[0], 4)) else $error("sts1 path");
    cover property (psel && penable && pwrite && paddr == LP_CMD_OFS);
    cover property (psel && penable && pslverr);
    cover property (tributary_loop_en[0]);
endmodule // lp_chk

bind lp_loop_ctrl lp_chk chk_i (.*);

// File: lp_far_model.sv
/* facility and switch side stream model.
   assumes outputs stay 0 until 9 cycles after reset. */
module lp_far_model
    import lp_pkg::*;
(
    input wire logic [1:0] far_go,
    input wire logic       pclk,
    input wire logic       presetn,
    output lp_sym_s        ds1_fac_rx [LP_NUM_DS1],
    output lp_sym_s        ds1_sw_rx  [LP_NUM_DS1],
    output lp_sym_s        sts1_fac_rx [LP_NUM_STS1],
    output lp_sym_s        sts1_sw_rx  [LP_NUM_STS1],
    output lp_sym_s        ds3_fac_rx [LP_NUM_DS3],
    output lp_sym_s        ds3_sw_rx  [LP_NUM_DS3],
    output logic [1:0]     ds3_far_loop_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic       run_r;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) cnt_r <= 8'h00;
        else cnt_r <= cnt_r + 8'h01;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) run_r <= 1'b0;
        else if (cnt_r == 8'h08) run_r <= 1'b1;
    // data toggles each cycle so a symbol one cycle stale never matches
    function automatic lp_sym_s pat(input int k);
        return run_r ? {cnt_r[0] ^ k[0], cnt_r[k % 4 + 1]} : 2'b00;
    endfunction
    always_comb
        for (int i = 0; i < LP_NUM_DS1; i++)
        begin
            ds1_fac_rx[i] = pat(i);
            ds1_sw_rx[i] = pat(i + 2);
            if (i < 2)
            begin
                sts1_fac_rx[i] = pat(i + 1);
                sts1_sw_rx[i] = pat(i + 3);
                ds3_fac_rx[i] = pat(i);
                ds3_sw_rx[i] = pat(i + 3);
            end
        end
    assign ds3_far_loop_req = far_go;
endmodule // lp_far_model

// File: lp_loop_ctrl_test.sv
/* apb sequence bench for the loop controller.
   assumes lp_far_model feeds all stream inputs. */
module lp_loop_ctrl_test
    import lp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [LP_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] far_go, tributary_loop_en, tributary_loop_far;
    lp_sym_s ds1_fac_rx [8], ds1_fac_tx [8], ds1_sw_rx [8], ds1_sw_tx [8];
    lp_sym_s sts1_fac_rx [2], sts1_fac_tx [2], sts1_sw_rx [2], sts1_sw_tx [2];
    lp_sym_s ds3_fac_rx [2], ds3_fac_tx [2], ds3_sw_rx [2], ds3_sw_tx [2], s;
    logic [1:0] ds3_far_loop_req;
    logic [LP_NUM_TRIB-1:0] vt_loop_mask [2];
    logic [4:0] tributary_loop_sel [2];
    int failures = 0, cmp_count = 0, cyc = 0;
    lp_loop_ctrl dut (.*);
    lp_far_model far_i (.*);
    always #4 pclk = ~pclk;
    task end_of_test;
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            end_of_test;
        end
    end
    task chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    function automatic logic [31:0] mk(int c, l, f, k, t, a, b);
        return {8'h80, 4'(b), 4'(a), 2'h0, 5'(t), 3'(k), 1'(f), 3'(l), 2'(c)};
    endfunction
    task cmd(input logic [31:0] c, input logic [3:0] e);
        apb(1'b1, LP_CMD_OFS, c);
        repeat (20)
        begin
            apb(1'b0, LP_STATUS_OFS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        chk("status", {28'h0, e}, rd);
    endtask
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, far_go} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LP_STATUS_OFS, 32'h0);
        chk("status rst", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        cmd(mk(0, 1, 0, 0, 0, 2, 5), 4'h2);
        cmd(mk(0, 2, 0, 0, 0, 3, 3), 4'hA);
        cmd(mk(0, 2, 0, 4, 0, 6, 6), 4'h4);
        cmd(mk(0, 3, 0, 0, 0, 6, 7), 4'h2);
        cmd(mk(2, 2, 1, 4, 0, 0, 0), 4'h4);
        cmd(mk(2, 2, 0, 4, 0, 0, 0), 4'h2);
        cmd(mk(2, 1, 0, 0, 0, 1, 1), 4'h2);
        cmd(mk(3, 2, 0, 4, 0, 1, 1), 4'h4);
        cmd(mk(3, 1, 0, 4, 5, 1, 1), 4'h4);
        cmd(mk(3, 2, 0, 4, 5, 1, 1), 4'h2);
        cmd(mk(1, 1, 0, 0, 0, 0, 0), 4'h4);
        cmd(mk(1, 4, 1, 2, 28, 0, 0), 4'h2);
        cmd(mk(0, 1, 0, 0, 0, 5, 2), 4'h4);
        apb(1'b0, LP_DS1_OFS, 32'h0);
        chk("ds1 modes", 32'h006C_9240, rd);
        apb(1'b0, LP_SONET_OFS, 32'h0);
        chk("sonet", 32'h041C_010A, rd);
        apb(1'b0, LP_VT1_OFS, 32'h0);
        chk("vt reg", 32'h10, rd);
        chk("vt mask", 32'h10, {4'h0, vt_loop_mask[1]});
        chk("trib", 32'h1C5, {23'h0, tributary_loop_sel[0],
            tributary_loop_far, tributary_loop_en});
        @(posedge pclk);
        #1 s = ds1_fac_rx[2];
        repeat (3) @(posedge pclk);
        #1 chk("ds1 loop", {30'h0, s}, {30'h0, ds1_fac_tx[2]});
        s = sts1_fac_rx[1];
        repeat (3) @(posedge pclk);
        #1 chk("sts1 loop", {30'h0, s}, {30'h0, sts1_fac_tx[1]});
        s = ds1_sw_rx[6];
        @(posedge pclk);
        #1 chk("ds1 int", {30'h0, s}, {30'h0, ds1_sw_tx[6]});
        @(posedge pclk);
        far_go <= 2'b10;
        repeat (6) @(posedge pclk);
        #1 s = ds3_fac_rx[1];
        repeat (3) @(posedge pclk);
        #1 chk("ds3 far", {30'h0, s}, {30'h0, ds3_fac_tx[1]});
        end_of_test;
    end
endmodule // lp_loop_ctrl_test
